// ===== ivp_pkg.sv
// Package for the interrupt vector priority block: constants and carrier types
// What this block does
// [R1] Vector n bytes at 0xFFFE minus 2n, high first
// [R2] Fixed priority, lower vector number wins
// [R3] Source event sets its flag regardless of enable
// [R4] Request only while flag and local enable set; vector 4 requests on the clock generator flag alone, with no enable
// [R5] Accept when mask clear, after current instruction
// [R6] Stack PC low, PC high, X, A, CONDITION_CODE_REG
// [R7] Set mask, fetch winning vector, jump there
// [R8] Vector 0 shared by reset causes, watchdog and low voltage gated
// [R9] Vector 15 from three serial flags, two enables
// [R10] Vector 4 from clock generator flag
// [R11] Global mask set out of reset
// [R12] Return restores CONDITION_CODE_REG, A, X, PC reversed
// [R13] Request holds until cleared; reselect each fetch
`default_nettype none
package ivp_pkg;
  localparam int unsigned NUM_VEC = 32;
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_SWTRAP = 5'h01;
  localparam logic [4:0] VEC_CLKGEN = 5'h04;
  localparam logic [4:0] VEC_SERIAL = 5'h0f;
  localparam logic [2:0] STK_PCL = 3'h0;
  localparam logic [2:0] STK_PCH = 3'h1;
  localparam logic [2:0] STK_X = 3'h2;
  localparam logic [2:0] STK_A = 3'h3;
  localparam logic [2:0] STK_CCR = 3'h4;
  localparam int unsigned CCR_I_BIT = 3;
  // Serial peripheral sources for vector 15
  typedef struct packed {
    logic serial_xfer_done_flag;
    logic serial_mode_fault_flag;
    logic serial_tx_empty_flag;
    logic serial_xfer_irq_enable;
    logic serial_tx_irq_enable;
  } ivp_serial_t;
  // Reset causes for vector 0
  typedef struct packed {
    logic watchdog_timeout;
    logic watchdog_enable;
    logic low_voltage;
    logic low_voltage_reset_enable;
    logic reset_pin;
    logic illegal_opcode;
  } ivp_reset_t;
  // Stack transfer toward the core
  typedef struct packed {
    logic valid;
    logic push;
    logic [2:0] slot;
  } ivp_stack_t;
endpackage : ivp_pkg
`default_nettype wire

// ===== ivp_ctrl.sv
// Interrupt flags, gating, priority select, entry/return sequencer
`default_nettype none
module ivp_ctrl #(
  parameter int unsigned NVEC = ivp_pkg::NUM_VEC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Generic sources, indexed by vector number
  input wire logic [NVEC-1:0] src_event_i,
  input wire logic [NVEC-1:0] src_clear_i,
  input wire logic [NVEC-1:0] src_enable_i,
  // Dedicated sources
  input wire ivp_pkg::ivp_reset_t rst_src_i,
  input wire ivp_pkg::ivp_serial_t serial_i,
  input wire logic clockgen_irq_flag_i,
  // Core handshake
  input wire logic insn_end_i,
  input wire logic swi_i,
  input wire logic rti_i,
  input wire logic mask_clear_i,
  input wire logic step_ack_i,
  // Outputs
  output logic [NVEC-1:0] irq_req_o,
  output logic reset_req_o,
  output var ivp_pkg::ivp_stack_t stack_o,
  output logic mask_o,
  output logic [15:0] vec_addr_o,
  output logic [4:0] vec_num_o,
  output logic vec_valid_o
);
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_PUSH = 4'h2,
    S_FETCH = 4'h4,
    S_POP = 4'h8
  } ivp_state_t;

  logic [NVEC-1:0] flag_ff, nxt_flag;   // Sticky source flags
  ivp_state_t state_ff, nxt_state;
  logic [2:0] slot_ff, nxt_slot;        // Stack slot counter
  logic mask_ff, nxt_mask;              // Global mask bit
  logic [15:0] addr_ff, nxt_addr;
  logic [4:0] num_ff, nxt_num;
  logic vld_ff, nxt_vld;
  logic [NVEC-1:0] req;
  logic [NVEC-1:0] req_all;
  logic [4:0] win;
  logic any;

  // Flags set on event; set beats clear so nothing is lost
  always_comb begin
    nxt_flag = (flag_ff & ~src_clear_i) | src_event_i; // see [R3]
  end

  // Gating: dedicated vectors override generic lanes
  always_comb begin
    req = flag_ff & src_enable_i; // see [R4] see [R13]
    req[ivp_pkg::VEC_CLKGEN] = clockgen_irq_flag_i; // see [R10]
    req[ivp_pkg::VEC_SERIAL] = ((serial_i.serial_xfer_done_flag |
      serial_i.serial_mode_fault_flag) & serial_i.serial_xfer_irq_enable) |
      (serial_i.serial_tx_empty_flag & serial_i.serial_tx_irq_enable); // see [R9]
    req[ivp_pkg::VEC_RESET] = 1'b0;
    req[ivp_pkg::VEC_SWTRAP] = 1'b0;
  end

  // Reset causes bypass the mask; they belong to vector 0
  assign reset_req_o = (rst_src_i.watchdog_timeout & rst_src_i.watchdog_enable) |
    (rst_src_i.low_voltage & rst_src_i.low_voltage_reset_enable) |
    rst_src_i.reset_pin | rst_src_i.illegal_opcode; // see [R8]
  assign irq_req_o = req;

  // Fixed priority: scan runs high to low, so the lowest number, found last, wins
  always_comb begin
    req_all = req;
    req_all[ivp_pkg::VEC_RESET] = reset_req_o;
    req_all[ivp_pkg::VEC_SWTRAP] = swi_i;
    win = 5'h00;
    any = 1'b0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (req_all[i]) begin
        win = 5'(i); // see [R2]
        any = 1'b1;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_mask = mask_ff;
    nxt_addr = addr_ff;
    nxt_num = num_ff;
    nxt_vld = 1'b0;
    unique case (state_ff)
      S_IDLE: begin
        if (mask_clear_i) begin
          nxt_mask = 1'b0;
        end
        // Reset or trap ignore mask; others wait on mask and instruction end
        if (reset_req_o) begin
          nxt_state = S_FETCH;
          nxt_mask = 1'b1;
        end else if (rti_i) begin
          nxt_state = S_POP;
          nxt_slot = ivp_pkg::STK_CCR; // see [R12]
        end else if (insn_end_i && (swi_i || (any && !mask_ff))) begin // see [R5]
          nxt_state = S_PUSH;
          nxt_slot = ivp_pkg::STK_PCL; // see [R6]
        end
      end
      S_PUSH: begin
        if (step_ack_i) begin
          if (slot_ff == ivp_pkg::STK_CCR) begin
            nxt_state = S_FETCH;
            nxt_mask = 1'b1; // see [R7]
          end else begin
            nxt_slot = slot_ff + 3'h1;
          end
        end
      end
      S_FETCH: begin
        // Re-evaluated here so a later, higher source can win
        nxt_num = win; // see [R13]
        nxt_addr = ivp_pkg::VEC_TOP - {10'h000, win, 1'b0}; // see [R1]
        nxt_vld = 1'b1; // see [R7]
        nxt_state = S_IDLE;
      end
      S_POP: begin
        if (step_ack_i) begin
          if (slot_ff == ivp_pkg::STK_CCR) begin
            nxt_mask = 1'b0; // Restored CONDITION_CODE_REG clears mask normally
          end
          if (slot_ff == ivp_pkg::STK_PCL) begin
            nxt_state = S_IDLE;
          end else begin
            nxt_slot = slot_ff - 3'h1; // see [R12]
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Registers; mask comes up set
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_ff <= '0;
      state_ff <= S_IDLE;
      slot_ff <= ivp_pkg::STK_PCL;
      mask_ff <= 1'b1; // see [R11]
      addr_ff <= ivp_pkg::VEC_TOP;
      num_ff <= ivp_pkg::VEC_RESET;
      vld_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      mask_ff <= nxt_mask;
      addr_ff <= nxt_addr;
      num_ff <= nxt_num;
      vld_ff <= nxt_vld;
    end
  end

  // Stack request as one word: a single driver for the whole carrier
  assign stack_o = '{valid: (state_ff == S_PUSH) || (state_ff == S_POP),
    push: (state_ff == S_PUSH), slot: slot_ff};
  assign mask_o = mask_ff;
  assign vec_addr_o = addr_ff;
  assign vec_num_o = num_ff;
  assign vec_valid_o = vld_ff;

  // Checks
  vec_addr_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
    vec_valid_o |-> vec_addr_o == 16'(ivp_pkg::VEC_TOP - {vec_num_o, 1'b0})) // see [R1]
    else $error("vector address mismatch");
  mask_reset_a: assert property (@(posedge clk_i) $fell(srst_i) |-> mask_o) // see [R11]
    else $error("mask not set after reset");
  gate_req_a: assert property (@(posedge clk_i) disable iff (srst_i)
    irq_req_o[5] == (flag_ff[5] && src_enable_i[5])) // see [R4]
    else $error("request gating wrong");
  flag_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    src_event_i[5] |=> flag_ff[5]) // see [R3]
    else $error("flag lost on event");
  accept_mask_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_ff == S_IDLE && !reset_req_o && !rti_i && !swi_i && mask_ff)
    |=> state_ff != S_PUSH) // see [R5]
    else $error("accepted while masked");
  push_order_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (stack_o.push && step_ack_i && slot_ff != ivp_pkg::STK_CCR)
    |=> stack_o.slot == $past(slot_ff) + 3'h1) // see [R6]
    else $error("stack order wrong");
  fetch_mask_a: assert property (@(posedge clk_i) disable iff (srst_i)
    vec_valid_o |-> mask_o) // see [R7]
    else $error("mask clear at fetch");
  prio_win_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_ff == S_FETCH && req_all[2] && !req_all[1] && !req_all[0])
    |=> vec_num_o == 5'h02) // see [R2]
    else $error("priority wrong");
  reset_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rst_src_i.watchdog_timeout && !rst_src_i.watchdog_enable && !rst_src_i.low_voltage
     && !rst_src_i.reset_pin && !rst_src_i.illegal_opcode) |-> !reset_req_o) // see [R8]
    else $error("gated reset leaked");
  pop_order_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_ff == S_POP && step_ack_i && slot_ff != ivp_pkg::STK_PCL)
    |=> stack_o.slot == $past(slot_ff) - 3'h1) // see [R12]
    else $error("unstack order wrong");
  serial_req_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (serial_i.serial_tx_empty_flag && serial_i.serial_tx_irq_enable) |-> irq_req_o[15]) // see [R9]
    else $error("serial request missing");
  clkgen_req_a: assert property (@(posedge clk_i) disable iff (srst_i)
    irq_req_o[4] == clockgen_irq_flag_i) // see [R10]
    else $error("clock request wrong");
  cov_entry_c: cover property (@(posedge clk_i) state_ff == S_PUSH ##[1:40] vec_valid_o);
  cov_return_c: cover property (@(posedge clk_i) state_ff == S_POP);
  cov_reset_c: cover property (@(posedge clk_i) vec_valid_o && vec_num_o == 5'h00);
endmodule : ivp_ctrl
`default_nettype wire

// ===== ivp_core_model.sv
// Core-side model: accepts stacked bytes promptly or every other cycle
`default_nettype none
module ivp_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pacing and stack request
  input wire logic slow_i,
  input wire ivp_pkg::ivp_stack_t stack_i,
  // Slot accepted
  output logic step_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase_ff; // Slow mode skips alternate cycles
  // Phase toggles freely so that slow acks land on both edges parities
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_ff <= 1'h0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end
  // One byte per ack, in whatever order the block presents
  assign step_ack_o = stack_i.valid & (~slow_i | phase_ff);
endmodule // ivp_core_model
`default_nettype wire

// ===== ivp_ctrl_tb.sv
// Testbench for the interrupt vector priority block
`default_nettype none
module ivp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, srst_i, clockgen_irq_flag_i, insn_end_i, swi_i, rti_i, mask_clear_i;
  logic step_ack_i, slow_ack, reset_req_o, mask_o, vec_valid_o;
  logic [31:0] src_event_i, src_clear_i, src_enable_i, irq_req_o;
  ivp_pkg::ivp_reset_t rst_src_i;
  ivp_pkg::ivp_serial_t serial_i;
  ivp_pkg::ivp_stack_t stack_o;
  logic [15:0] vec_addr_o;
  logic [4:0] vec_num_o;
  int n_fail, samples_checked, cycles;
  ivp_ctrl ivp_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i), .src_event_i(src_event_i),
    .src_clear_i(src_clear_i), .src_enable_i(src_enable_i), .rst_src_i(rst_src_i),
    .serial_i(serial_i), .clockgen_irq_flag_i(clockgen_irq_flag_i), .insn_end_i(insn_end_i),
    .swi_i(swi_i), .rti_i(rti_i), .mask_clear_i(mask_clear_i), .step_ack_i(step_ack_i),
    .irq_req_o(irq_req_o), .reset_req_o(reset_req_o), .stack_o(stack_o), .mask_o(mask_o),
    .vec_addr_o(vec_addr_o), .vec_num_o(vec_num_o), .vec_valid_o(vec_valid_o));
  ivp_core_model ivp_core_model_inst (.clk_i(clk_i), .srst_i(srst_i), .slow_i(slow_ack),
    .stack_i(stack_o), .step_ack_o(step_ack_i));
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  // Verdict and counts
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Follows one stacking or unstacking pass; sampled mid-cycle where all is settled
  task automatic watch(input logic push, input logic [4:0] n, input int slots);
    int k;
    k = 0;
    for (int t = 0; t < 80; t++) begin
      @(negedge clk_i);
      if (vec_valid_o === 1'h1) break;
      if (stack_o.valid === 1'h1 && step_ack_i === 1'h1) begin
        chk("slot", push ? k : 4 - k, {13'h0, stack_o.slot});
        chk("direction", push, stack_o.push);
        k++;
      end
      if (!push && k == slots) break;
    end
    chk("slot count", slots, k);
    if (push) begin
      chk("vector address", 16'hfffe - {n, 1'h0}, vec_addr_o);
      chk("vector number", n, vec_num_o);
      chk("mask at fetch", 1'h1, mask_o);
    end
  endtask
  task automatic t_reset();
    @(negedge clk_i);
    chk("mask after reset", 1'h1, mask_o);
    chk("idle outputs", 2'h0, {vec_valid_o, stack_o.valid});
    chk("reset vector", 16'hfffe, vec_addr_o);
  endtask
  // Flags latch while disabled; enables gate; dedicated lanes 4 and 15
  task automatic t_gate();
    @(posedge clk_i);
    src_event_i[5] <= 1'h1;
    serial_i.serial_tx_empty_flag <= 1'h1;
    clockgen_irq_flag_i <= 1'h1;
    @(posedge clk_i);
    src_event_i[5] <= 1'h0;
    @(negedge clk_i);
    chk("lane 5 disabled", 1'h0, irq_req_o[5]);
    chk("lane 15 disabled", 1'h0, irq_req_o[15]);
    chk("lane 4", 1'h1, irq_req_o[4]);
    @(posedge clk_i);
    src_enable_i[5] <= 1'h1;
    serial_i.serial_tx_irq_enable <= 1'h1;
    @(negedge clk_i);
    chk("lane 5 enabled", 1'h1, irq_req_o[5]);
    chk("lane 15 tx", 1'h1, irq_req_o[15]);
    @(posedge clk_i);
    src_clear_i[5] <= 1'h1;
    clockgen_irq_flag_i <= 1'h0;
    serial_i <= 5'h12;
    @(posedge clk_i);
    src_clear_i[5] <= 1'h0;
    @(negedge clk_i);
    chk("lane 5 cleared", 1'h0, irq_req_o[5]);
    chk("lane 15 xfer", 1'h1, irq_req_o[15]);
    chk("lane 4 off", 1'h0, irq_req_o[4]);
    // Event and clear in one cycle: the event must not be lost
    @(posedge clk_i);
    serial_i <= 5'h0;
    src_event_i[5] <= 1'h1;
    src_clear_i[5] <= 1'h1;
    @(posedge clk_i);
    src_event_i[5] <= 1'h0;
    @(negedge clk_i);
    chk("set beats clear", 1'h1, irq_req_o[5]);
    @(posedge clk_i);
    src_clear_i[5] <= 1'h0;
  endtask
  // Two pending, masked at a boundary, then mid instruction; return; reselect
  task automatic t_entry();
    @(posedge clk_i);
    src_event_i[2] <= 1'h1;
    src_event_i[7] <= 1'h1;
    src_enable_i[2] <= 1'h1;
    src_enable_i[7] <= 1'h1;
    insn_end_i <= 1'h1;
    repeat (3) @(negedge clk_i);
    chk("masked hold", 1'h0, stack_o.valid);
    @(posedge clk_i);
    src_event_i <= 32'h0;
    mask_clear_i <= 1'h1;
    insn_end_i <= 1'h0;
    @(posedge clk_i);
    mask_clear_i <= 1'h0;
    repeat (3) @(negedge clk_i);
    chk("mid instruction", 2'h0, {mask_o, stack_o.valid});
    @(posedge clk_i);
    insn_end_i <= 1'h1;
    watch(1'h1, 5'h02, 5);
    @(posedge clk_i);
    src_clear_i[2] <= 1'h1;
    rti_i <= 1'h1;
    slow_ack <= 1'h1;
    @(posedge clk_i);
    src_clear_i[2] <= 1'h0;
    rti_i <= 1'h0;
    watch(1'h0, 5'h00, 5);
    chk("mask after return", 1'h0, mask_o);
    watch(1'h1, 5'h07, 5);
  endtask
  // Trap enters although masked and outranks the pending lane 7
  task automatic t_swtrap();
    @(posedge clk_i);
    swi_i <= 1'h1;
    @(posedge clk_i);
    insn_end_i <= 1'h0;
    watch(1'h1, 5'h01, 5);
    @(posedge clk_i);
    swi_i <= 1'h0;
  endtask
  // Gated reset causes; enabled cause outranks lane 7, no stacking
  task automatic t_rstcause();
    @(posedge clk_i);
    rst_src_i.watchdog_timeout <= 1'h1;
    rst_src_i.low_voltage <= 1'h1;
    @(negedge clk_i);
    chk("causes gated", 1'h0, reset_req_o);
    @(posedge clk_i);
    rst_src_i.watchdog_enable <= 1'h1;
    @(negedge clk_i);
    chk("watchdog", 1'h1, reset_req_o);
    // Cause held through the fetch, since the winner is picked there
    watch(1'h1, 5'h00, 0);
    @(posedge clk_i);
    rst_src_i <= 6'h0;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    {srst_i, insn_end_i, swi_i, rti_i, mask_clear_i, slow_ack, clockgen_irq_flag_i} = 7'h40;
    {src_event_i, src_clear_i, src_enable_i} = 96'h0;
    rst_src_i = 6'h0;
    serial_i = 5'h0;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'h0;
    t_reset();
    t_gate();
    t_entry();
    t_swtrap();
    t_rstcause();
    complete_run();
  end
endmodule // ivp_ctrl_tb
`default_nettype wire
